// ---- hw/nvm_ctrl.sv ----
// one-time programmable memory controller: registers, buffer and burn/load sequencer
// Behaviour
// - 128-byte staging buffer at 0x7000..0x707F holds burn data or loaded data.
// - 108 array bytes reserved for factory; 0x7018..0x702B free for users.
// - bits burn once, so burning starts only on an explicit host request.
// - writing 0x01 to 0x3D80 starts burning the buffer; trigger is write-only.
// - bit 7 of 0x3D80 reads as write-busy during programming.
// - writing 0x01 to 0x3D81 loads array into buffer; bit 7 reads load-busy.
// - 0x3D81 has self-test error/done flags, result-clear and autoload-select write bits.
// - program strobe width from 0x3D82 in eight-clock units, reset 0x65.
// - load strobe width from 0x3D83 in clocks, reset 0x06.
// - 0x3D84: bit 7 blocks burning, bit 6 manual mode, bit 0 bank switch.
// - manual mode limits load and burn to the start..end address range.
// - 0x3D85 self-test: bit 4 enable, bit 5 mode, bit 6 compare value; reset 0x1B.
// - on self-test mismatch the first failing address since the last result clear goes to 0x3D8E/0x3D8F.
// - 0x3D86 drives buffer ram test from bit 4, read margin bits 2:0; reset 0x0F.
`timescale 1ns/1ns
module nvm_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register access from the serial control port
  input wire nvm_pkg::reg_req_type reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // array macro
  output nvm_pkg::array_out_type array_out,
  input wire logic [7:0] array_rdata,
  // static controls
  output logic buffer_ram_test,
  output logic [2:0] buffer_ram_read_margin,
  output logic bank_buffer_switch,
  output logic autoload_select
);
  localparam int iw = nvm_pkg::idx_w;
  logic [7:0] pgm_width_reg, pgm_width_next, ld_width_reg, ld_width_next;
  logic [7:0] mode_reg, mode_next, bist_reg, bist_next, ram_test_reg, ram_test_next;
  logic [7:0] ps2cs_reg, ps2cs_next, start_hi_reg, start_hi_next, start_lo_reg, start_lo_next;
  logic [7:0] end_hi_reg, end_hi_next, end_lo_reg, end_lo_next;
  logic autoload_reg, autoload_next;
  nvm_pkg::seq_state_type state_reg, state_next;
  logic [iw-1:0] idx_reg, idx_next, first_idx, last_idx;
  logic op_load_reg, op_load_next, prog_busy_reg, prog_busy_next, load_busy_reg, load_busy_next;
  logic bist_err_reg, bist_err_next, bist_done_reg, bist_done_next;
  logic [15:0] fail_addr_reg, fail_addr_next;
  logic [3:0] strobe_reg, strobe_next;
  logic [7:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next, rsel_buf_reg, rsel_buf_next;
  logic prog_hit, load_hit, clear_hit, host_buf_wr, seq_wr, mismatch, bist_set;
  logic tmr_start, tmr_done;
  logic [nvm_pkg::cnt_w-1:0] tmr_count;
  logic [7:0] buf_host_data, buf_seq_data;
  logic [11:0] phase_cnt_reg;
  // write decode for triggers; disable bit or busy keeps the array untouched
  always_comb begin
    prog_hit = reg_req.wr && (reg_req.addr == nvm_pkg::prog_ctrl_addr) && reg_req.wdata[nvm_pkg::trig_bit]
               && !mode_reg[nvm_pkg::prog_dis_bit];
    load_hit = reg_req.wr && (reg_req.addr == nvm_pkg::load_ctrl_addr) && reg_req.wdata[nvm_pkg::trig_bit];
    clear_hit = reg_req.wr && (reg_req.addr == nvm_pkg::load_ctrl_addr) && reg_req.wdata[nvm_pkg::clr_bit];
    // user bytes share the one window; host writes to the buffer are dropped while busy
    host_buf_wr = reg_req.wr && nvm_pkg::is_buf_addr(reg_req.addr) && !prog_busy_reg && !load_busy_reg;
  end
  // configuration registers
  always_comb begin
    pgm_width_next = pgm_width_reg;
    ld_width_next = ld_width_reg;
    mode_next = mode_reg;
    bist_next = bist_reg;
    ram_test_next = ram_test_reg;
    ps2cs_next = ps2cs_reg;
    start_hi_next = start_hi_reg;
    start_lo_next = start_lo_reg;
    end_hi_next = end_hi_reg;
    end_lo_next = end_lo_reg;
    autoload_next = autoload_reg;
    if (reg_req.wr) begin
      case (reg_req.addr)
        nvm_pkg::load_ctrl_addr: autoload_next = reg_req.wdata[nvm_pkg::autoload_bit];
        nvm_pkg::pgm_width_addr: pgm_width_next = reg_req.wdata;
        nvm_pkg::ld_width_addr: ld_width_next = reg_req.wdata;
        nvm_pkg::mode_addr: mode_next = reg_req.wdata;
        nvm_pkg::bist_addr: bist_next = reg_req.wdata;
        nvm_pkg::ram_test_addr: ram_test_next = reg_req.wdata;
        nvm_pkg::ps2cs_addr: ps2cs_next = reg_req.wdata;
        nvm_pkg::start_hi_addr: start_hi_next = reg_req.wdata;
        nvm_pkg::start_lo_addr: start_lo_next = reg_req.wdata;
        nvm_pkg::end_hi_addr: end_hi_next = reg_req.wdata;
        nvm_pkg::end_lo_addr: end_lo_next = reg_req.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pgm_width_reg <= nvm_pkg::pgm_width_rst;
      ld_width_reg <= nvm_pkg::ld_width_rst;
      mode_reg <= nvm_pkg::mode_rst;
      bist_reg <= nvm_pkg::bist_rst;
      ram_test_reg <= nvm_pkg::ram_test_rst;
      ps2cs_reg <= nvm_pkg::ps2cs_rst;
      start_hi_reg <= nvm_pkg::range_rst;
      start_lo_reg <= nvm_pkg::range_rst;
      end_hi_reg <= nvm_pkg::range_rst;
      end_lo_reg <= nvm_pkg::range_rst;
      autoload_reg <= 1'b0;
    end else begin
      pgm_width_reg <= pgm_width_next;
      ld_width_reg <= ld_width_next;
      mode_reg <= mode_next;
      bist_reg <= bist_next;
      ram_test_reg <= ram_test_next;
      ps2cs_reg <= ps2cs_next;
      start_hi_reg <= start_hi_next;
      start_lo_reg <= start_lo_next;
      end_hi_reg <= end_hi_next;
      end_lo_reg <= end_lo_next;
      autoload_reg <= autoload_next;
    end
  end
  // range: the high bytes only name the window, so the low bytes pick the index
  always_comb begin
    first_idx = mode_reg[nvm_pkg::manual_bit] ? start_lo_reg[iw-1:0] : nvm_pkg::idx_first;
    last_idx = mode_reg[nvm_pkg::manual_bit] ? end_lo_reg[iw-1:0] : nvm_pkg::idx_max;
    // blank check against the compare value, or verify against the buffer
    mismatch = bist_reg[nvm_pkg::bist_mode_bit] ? (array_rdata != buf_seq_data)
               : (array_rdata != {8{bist_reg[nvm_pkg::cmp_bit]}});
  end
  // sequencer: select delay, strobe, advance, one byte per pass
  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    op_load_next = op_load_reg;
    prog_busy_next = prog_busy_reg;
    load_busy_next = load_busy_reg;
    bist_err_next = bist_err_reg;
    bist_done_next = bist_done_reg;
    fail_addr_next = fail_addr_reg;
    tmr_start = 1'b0;
    tmr_count = nvm_pkg::cnt_w'(ps2cs_reg);
    seq_wr = 1'b0;
    bist_set = 1'b0;
    // clear first so a same-cycle self-test event still lands
    if (clear_hit) begin
      bist_err_next = 1'b0;
      bist_done_next = 1'b0;
      fail_addr_next = 16'h0000;
    end
    unique case (state_reg)
      nvm_pkg::st_idle: begin
        // triggers are only looked at here, so they drop while busy
        if (prog_hit || load_hit) begin
          state_next = nvm_pkg::st_select;
          idx_next = first_idx;
          op_load_next = load_hit;
          prog_busy_next = prog_hit;
          load_busy_next = load_hit;
          tmr_start = 1'b1;
        end
      end
      nvm_pkg::st_select: begin
        if (tmr_done) begin
          state_next = nvm_pkg::st_strobe;
          tmr_start = 1'b1;
          tmr_count = op_load_reg ? nvm_pkg::cnt_w'(ld_width_reg)
                      : nvm_pkg::cnt_w'(nvm_pkg::cnt_w'(pgm_width_reg) << nvm_pkg::pgm_unit_shift);
        end
      end
      nvm_pkg::st_strobe: begin
        if (tmr_done) begin
          state_next = nvm_pkg::st_advance;
          seq_wr = op_load_reg;
          if (op_load_reg && bist_reg[nvm_pkg::bist_en_bit] && mismatch) begin
            bist_set = 1'b1;
            // keep the first failing address since the last result clear
            if (!bist_err_next) begin
              fail_addr_next = nvm_pkg::buf_first_addr | 16'(idx_reg);
            end
            bist_err_next = 1'b1;
          end
        end
      end
      nvm_pkg::st_advance: begin
        if ((idx_reg == last_idx) || (idx_reg == nvm_pkg::idx_max)) begin
          state_next = nvm_pkg::st_idle;
          prog_busy_next = 1'b0;
          load_busy_next = 1'b0;
          if (op_load_reg && bist_reg[nvm_pkg::bist_en_bit]) begin
            bist_done_next = 1'b1;
          end
        end else begin
          idx_next = idx_reg + iw'(1);
          state_next = nvm_pkg::st_select;
          tmr_start = 1'b1;
        end
      end
    endcase
    // array pins follow the next state so they line up with it
    strobe_next[3] = state_next != nvm_pkg::st_strobe;
    strobe_next[2] = (state_next == nvm_pkg::st_select) || (state_next == nvm_pkg::st_strobe);
    strobe_next[1] = (state_next == nvm_pkg::st_strobe) && !op_load_next;
    strobe_next[0] = (state_next == nvm_pkg::st_strobe) && op_load_next;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= nvm_pkg::st_idle;
      idx_reg <= nvm_pkg::idx_first;
      op_load_reg <= 1'b0;
      prog_busy_reg <= 1'b0;
      load_busy_reg <= 1'b0;
      bist_err_reg <= 1'b0;
      bist_done_reg <= 1'b0;
      fail_addr_reg <= 16'h0000;
      strobe_reg <= 4'h8;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      op_load_reg <= op_load_next;
      prog_busy_reg <= prog_busy_next;
      load_busy_reg <= load_busy_next;
      bist_err_reg <= bist_err_next;
      bist_done_reg <= bist_done_next;
      fail_addr_reg <= fail_addr_next;
      strobe_reg <= strobe_next;
    end
  end
  // read path: one clock latency for registers and buffer alike
  always_comb begin
    rdata_next = rdata_reg;
    rvalid_next = reg_req.rd;
    rsel_buf_next = rsel_buf_reg;
    if (reg_req.rd) begin
      rdata_next = 8'h00;
      rsel_buf_next = nvm_pkg::is_buf_addr(reg_req.addr);
      case (reg_req.addr)
        nvm_pkg::prog_ctrl_addr: rdata_next[nvm_pkg::busy_bit] = prog_busy_reg;
        nvm_pkg::load_ctrl_addr: begin
          rdata_next[nvm_pkg::busy_bit] = load_busy_reg;
          rdata_next[nvm_pkg::err_bit] = bist_err_reg;
          rdata_next[nvm_pkg::done_bit] = bist_done_reg;
        end
        nvm_pkg::pgm_width_addr: rdata_next = pgm_width_reg;
        nvm_pkg::ld_width_addr: rdata_next = ld_width_reg;
        nvm_pkg::mode_addr: rdata_next = mode_reg;
        nvm_pkg::bist_addr: rdata_next = bist_reg;
        nvm_pkg::ram_test_addr: rdata_next = ram_test_reg;
        nvm_pkg::ps2cs_addr: rdata_next = ps2cs_reg;
        nvm_pkg::start_hi_addr: rdata_next = start_hi_reg;
        nvm_pkg::start_lo_addr: rdata_next = start_lo_reg;
        nvm_pkg::end_hi_addr: rdata_next = end_hi_reg;
        nvm_pkg::end_lo_addr: rdata_next = end_lo_reg;
        nvm_pkg::fail_hi_addr: rdata_next = fail_addr_reg[15:8];
        nvm_pkg::fail_lo_addr: rdata_next = fail_addr_reg[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
      rsel_buf_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      rsel_buf_reg <= rsel_buf_next;
    end
  end
  strobe_timer u_timer (.clk(clk), .arst_n(arst_n), .start(tmr_start), .count(tmr_count), .done(tmr_done));
  // host writes and loaded bytes share one write port; busy keeps them from meeting
  staging_buffer u_buffer (.clk(clk), .arst_n(arst_n), .wr_en(host_buf_wr || seq_wr),
    .wr_idx(seq_wr ? idx_reg : reg_req.addr[iw-1:0]), .wr_data(seq_wr ? array_rdata : reg_req.wdata),
    .host_idx(reg_req.addr[iw-1:0]), .host_data(buf_host_data), .seq_idx(idx_reg), .seq_data(buf_seq_data));
  // outputs
  assign reg_rdata = rsel_buf_reg ? buf_host_data : rdata_reg;
  assign reg_rvalid = rvalid_reg;
  assign array_out = '{strobe_reg[3], strobe_reg[2], strobe_reg[1], strobe_reg[0], idx_reg, buf_seq_data};
  assign buffer_ram_test = ram_test_reg[nvm_pkg::ram_test_bit];
  assign buffer_ram_read_margin = ram_test_reg[nvm_pkg::rm_msb:0];
  assign bank_buffer_switch = mode_reg[nvm_pkg::bank_sw_bit];
  assign autoload_select = autoload_reg;
  // helper: clocks spent in the current sequencer state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_cnt_reg <= 12'h000;
    end else begin
      phase_cnt_reg <= (state_next != state_reg) ? 12'h000 : phase_cnt_reg + 12'h001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_trigger;
    state_reg == nvm_pkg::st_idle && (prog_hit || load_hit);
  endsequence
  sequence s_started;
    (prog_busy_reg || load_busy_reg) && state_reg == nvm_pkg::st_select && idx_reg == $past(first_idx);
  endsequence
  a_busy_on_trigger: assert property (s_trigger |=> s_started)
    else $error("busy or first index wrong after trigger");
  a_busy_holds: assert property (state_reg != nvm_pkg::st_idle |-> prog_busy_reg || load_busy_reg)
    else $error("busy dropped mid sequence");
  a_prog_disabled: assert property (state_reg == nvm_pkg::st_idle && mode_reg[nvm_pkg::prog_dis_bit]
    && !load_hit |=> !prog_busy_reg)
    else $error("burn started while disabled");
  a_prog_busy_read: assert property (reg_req.rd && reg_req.addr == nvm_pkg::prog_ctrl_addr
    |=> reg_rdata == {$past(prog_busy_reg), 7'h00})
    else $error("write busy readback wrong");
  a_select_delay: assert property (state_reg == nvm_pkg::st_select && tmr_done
    |-> phase_cnt_reg + 12'd1 == ((ps2cs_reg == 8'h00) ? 12'd1 : 12'(ps2cs_reg)))
    else $error("select to chip select delay wrong");
  a_load_width: assert property (state_reg == nvm_pkg::st_strobe && tmr_done && op_load_reg
    |-> phase_cnt_reg + 12'd1 == ((ld_width_reg == 8'h00) ? 12'd1 : 12'(ld_width_reg)))
    else $error("load strobe width wrong");
  a_prog_width: assert property (state_reg == nvm_pkg::st_strobe && tmr_done && !op_load_reg
    |-> phase_cnt_reg + 12'd1 == ((pgm_width_reg == 8'h00) ? 12'd1 : {1'b0, pgm_width_reg, 3'b000}))
    else $error("program strobe width wrong");
  a_chip_select: assert property (array_out.prog_strobe || array_out.load_strobe
    |-> !array_out.array_chip_select_n && array_out.program_select_strobe)
    else $error("strobe without chip select");
  a_fail_capture: assert property (bist_set && !bist_err_reg |=> bist_err_reg && fail_addr_reg[6:0] == $past(idx_reg))
    else $error("failing address not captured");
  a_result_clear: assert property (clear_hit && !bist_set && !(bist_done_next && !clear_hit)
    && state_reg != nvm_pkg::st_advance |=> !bist_err_reg && !bist_done_reg && fail_addr_reg == 16'h0000)
    else $error("result clear left flags set");
endmodule // nvm_ctrl

// ---- hw/nvm_pkg.sv ----
// shared constants, carriers and states of the one-time programmable memory controller
package nvm_pkg;
  // widths
  localparam int idx_w = 7;
  localparam int cnt_w = 11;
  localparam int buf_depth = 128;
  localparam logic [idx_w-1:0] idx_first = 7'h00;
  localparam logic [idx_w-1:0] idx_max = 7'h7f;
  // register offsets
  localparam logic [15:0] prog_ctrl_addr = 16'h3d80;
  localparam logic [15:0] load_ctrl_addr = 16'h3d81;
  localparam logic [15:0] pgm_width_addr = 16'h3d82;
  localparam logic [15:0] ld_width_addr = 16'h3d83;
  localparam logic [15:0] mode_addr = 16'h3d84;
  localparam logic [15:0] bist_addr = 16'h3d85;
  localparam logic [15:0] ram_test_addr = 16'h3d86;
  localparam logic [15:0] ps2cs_addr = 16'h3d87;
  localparam logic [15:0] start_hi_addr = 16'h3d88;
  localparam logic [15:0] start_lo_addr = 16'h3d89;
  localparam logic [15:0] end_hi_addr = 16'h3d8a;
  localparam logic [15:0] end_lo_addr = 16'h3d8b;
  localparam logic [15:0] fail_hi_addr = 16'h3d8e;
  localparam logic [15:0] fail_lo_addr = 16'h3d8f;
  // staging buffer window and the bytes left free for users
  localparam logic [15:0] buf_first_addr = 16'h7000;
  localparam logic [15:0] buf_last_addr = 16'h707f;
  localparam logic [15:0] user_first_addr = 16'h7018;
  localparam logic [15:0] user_last_addr = 16'h702b;
  // field positions
  localparam int busy_bit = 7;
  localparam int trig_bit = 0;
  localparam int err_bit = 5;
  localparam int done_bit = 4;
  localparam int clr_bit = 2;
  localparam int autoload_bit = 1;
  localparam int prog_dis_bit = 7;
  localparam int manual_bit = 6;
  localparam int bank_sw_bit = 0;
  localparam int cmp_bit = 6;
  localparam int bist_mode_bit = 5;
  localparam int bist_en_bit = 4;
  localparam int ram_test_bit = 4;
  localparam int rm_msb = 2;
  // program strobe unit is eight clocks
  localparam int pgm_unit_shift = 3;
  // reset values
  localparam logic [7:0] pgm_width_rst = 8'h65;
  localparam logic [7:0] ld_width_rst = 8'h06;
  localparam logic [7:0] mode_rst = 8'h00;
  localparam logic [7:0] bist_rst = 8'h1b;
  localparam logic [7:0] ram_test_rst = 8'h0f;
  localparam logic [7:0] ps2cs_rst = 8'h0a;
  localparam logic [7:0] range_rst = 8'h00;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic array_chip_select_n;
    logic program_select_strobe;
    logic prog_strobe;
    logic load_strobe;
    logic [idx_w-1:0] addr;
    logic [7:0] wdata;
  } array_out_type;

  typedef enum logic [3:0] {
    st_idle = 4'b0001,
    st_select = 4'b0010,
    st_strobe = 4'b0100,
    st_advance = 4'b1000
  } seq_state_type;

  // true for an offset inside the staging buffer window
  function automatic logic is_buf_addr(input logic [15:0] a);
    return (a >= buf_first_addr) && (a <= buf_last_addr);
  endfunction
endpackage

// ---- hw/strobe_timer.sv ----
// down counter that times select delays and strobe widths
`timescale 1ns/1ns
module strobe_timer (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // start request and length in clocks
  input wire logic start,
  input wire logic [nvm_pkg::cnt_w-1:0] count,
  // last cycle of the timed phase
  output logic done
);
  logic [nvm_pkg::cnt_w-1:0] cnt_reg, cnt_next;
  logic run_reg, run_next;

  // a zero length still lasts one clock so the sequence never stalls
  always_comb begin
    cnt_next = cnt_reg;
    run_next = run_reg;
    if (start) begin
      run_next = 1'b1;
      cnt_next = (count == '0) ? nvm_pkg::cnt_w'(1) : count;
    end else if (done) begin
      run_next = 1'b0;
    end else if (run_reg) begin
      cnt_next = cnt_reg - nvm_pkg::cnt_w'(1);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      run_reg <= run_next;
    end
  end

  assign done = run_reg && (cnt_reg == nvm_pkg::cnt_w'(1));
endmodule // strobe_timer

// ---- hw/staging_buffer.sv ----
// 128-byte staging buffer, one write port and two registered read ports
`timescale 1ns/1ns
module staging_buffer (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // write port
  input wire logic wr_en,
  input wire logic [nvm_pkg::idx_w-1:0] wr_idx,
  input wire logic [7:0] wr_data,
  // host read port
  input wire logic [nvm_pkg::idx_w-1:0] host_idx,
  output logic [7:0] host_data,
  // sequencer read port
  input wire logic [nvm_pkg::idx_w-1:0] seq_idx,
  output logic [7:0] seq_data
);
  logic [7:0] mem [nvm_pkg::buf_depth];
  logic [7:0] host_next, seq_next;

  // contents carry no reset; software clears unused bytes before a burn
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  // both read ports see the array one clock after the index
  always_comb begin
    host_next = mem[host_idx];
    seq_next = mem[seq_idx];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      host_data <= 8'h00;
      seq_data <= 8'h00;
    end else begin
      host_data <= host_next;
      seq_data <= seq_next;
    end
  end
endmodule // staging_buffer

// ---- bench/array_model.sv ----
// behavioural model of the one-time programmable array macro
`timescale 1ns/1ns
module array_model (
  // clock
  input wire logic clk,
  // array link from the controller
  input wire nvm_pkg::array_out_type array_out,
  output logic [7:0] array_rdata
);
  logic [7:0] mem [128];
  logic [7:0] last = 8'h00;
  // blank array at power up
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'h00;
    end
  end
  // burning only sets bits, so a burnt bit can never be taken back
  always @(posedge clk) begin
    if (!array_out.array_chip_select_n && array_out.prog_strobe) begin
      mem[array_out.addr] <= mem[array_out.addr] | array_out.wdata;
    end
    if (!array_out.array_chip_select_n && array_out.load_strobe) begin
      last <= mem[array_out.addr];
    end
  end
  // released data lines show the inverse of the last value, never a stale copy
  assign array_rdata = (!array_out.array_chip_select_n && array_out.load_strobe) ? mem[array_out.addr] : ~last;
endmodule // array_model

// ---- bench/nvm_ctrl_bench.sv ----
// self-checking testbench of the one-time programmable memory controller
`timescale 1ns/1ns
module nvm_ctrl_bench;
  logic clk;
  logic arst_n;
  nvm_pkg::reg_req_type req;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  nvm_pkg::array_out_type array_out;
  logic [7:0] array_rdata;
  logic ram_test;
  logic [2:0] margin;
  logic bank_sw;
  logic autoload;
  logic [7:0] got;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  // register offsets and their reset values
  logic [15:0] rst_addr [8] = '{16'h3d82, 16'h3d83, 16'h3d84, 16'h3d85, 16'h3d86, 16'h3d87, 16'h3d89, 16'h3d8b};
  logic [7:0] rst_val [8] = '{8'h65, 8'h06, 8'h00, 8'h1b, 8'h0f, 8'h0a, 8'h00, 8'h00};

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  nvm_ctrl nvm_ctrl_inst (.clk(clk), .arst_n(arst_n), .reg_req(req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .array_out(array_out), .array_rdata(array_rdata), .buffer_ram_test(ram_test),
    .buffer_ram_read_margin(margin), .bank_buffer_switch(bank_sw), .autoload_select(autoload));
  array_model array_model_inst (.clk(clk), .array_out(array_out), .array_rdata(array_rdata));

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one-cycle write strobe, launched off the falling edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge clk);
    req.wr = 1'b0;
  endtask

  // read data is taken in the valid cycle, one clock after the strobe
  task automatic rd(input logic [15:0] a);
    @(negedge clk);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk);
    req.rd = 1'b0;
    got = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
  endtask

  task automatic rdc(input logic [15:0] a, input logic [7:0] exp, input string what);
    rd(a);
    check(what, exp, got);
  endtask

  // bounded poll of a busy flag in bit 7
  task automatic wait_idle(input logic [15:0] a);
    for (int i = 0; i < 200; i++) begin
      rd(a);
      if (got[7] === 1'b0) break;
    end
    check("busy flag", 8'h00, {got[7], 7'h00});
  endtask

  task complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // hang guard, far above the 160 cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      complete_run();
    end
  end

  initial begin
    req = '0;
    arst_n = 1'b0;
    repeat (8) @(negedge clk);
    arst_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      rdc(rst_addr[i], rst_val[i], "reset value");
    end
    check("read margin", 8'h07, {5'h00, margin});
    check("chip select idle", 8'h01, {7'h00, array_out.array_chip_select_n});
    $display("test reset values done");
    wr(16'h702b, 8'h5a);
    rdc(16'h702b, 8'h5a, "user byte");
    wr(16'h3d8c, 8'hff);
    rdc(16'h3d8c, 8'h00, "unmapped read");
    wr(16'h3d86, 8'h12);
    wr(16'h3d84, 8'h01);
    wr(16'h3d81, 8'h02);
    check("static outputs", 8'h3a, {2'h0, autoload, ram_test, bank_sw, margin});
    rdc(16'h3d81, 8'h00, "write-only bits");
    $display("test static outputs done");
    // short strobes, manual range 0x18..0x19
    wr(16'h3d87, 8'h01);
    wr(16'h3d83, 8'h02);
    wr(16'h3d82, 8'h01);
    wr(16'h3d84, 8'h40);
    wr(16'h3d89, 8'h18);
    wr(16'h3d8b, 8'h19);
    // short settle, scaled down from the start-up time after streaming
    repeat (4) @(negedge clk);
    // blank check by a load, self-test against zero from reset
    wr(16'h3d81, 8'h01);
    wait_idle(16'h3d81);
    rdc(16'h3d81, 8'h10, "blank check flags");
    rdc(16'h7019, 8'h00, "blank byte");
    wr(16'h3d81, 8'h04);
    wr(16'h7018, 8'ha5);
    wr(16'h7019, 8'h3c);
    wr(16'h701a, 8'h77);
    rdc(16'h7019, 8'h3c, "buffer read back");
    wr(16'h3d80, 8'h01);
    rdc(16'h3d80, 8'h80, "write busy");
    wr(16'h7018, 8'hff);
    // then stay off the bus until the burn is surely over
    repeat (30) @(negedge clk);
    wait_idle(16'h3d80);
    check("burnt byte", 8'ha5, array_model_inst.mem[24]);
    check("byte outside range", 8'h00, array_model_inst.mem[26]);
    $display("test program done");
    wr(16'h7018, 8'h00);
    wr(16'h3d85, 8'h10);
    wr(16'h3d81, 8'h01);
    wait_idle(16'h3d81);
    rdc(16'h7018, 8'ha5, "loaded byte");
    rdc(16'h7019, 8'h3c, "loaded second byte");
    rdc(16'h701a, 8'h77, "unloaded byte");
    rdc(16'h3d81, 8'h30, "self-test flags");
    rdc(16'h3d8e, 8'h70, "fail address high");
    rdc(16'h3d8f, 8'h18, "fail address low");
    wr(16'h3d81, 8'h04);
    rdc(16'h3d81, 8'h00, "cleared flags");
    rdc(16'h3d8f, 8'h00, "cleared address");
    $display("test load and self-test done");
    wr(16'h3d84, 8'hc0);
    wr(16'h3d80, 8'h01);
    rdc(16'h3d80, 8'h00, "disabled burn");
    $display("test program disable done");
    complete_run();
  end
endmodule // nvm_ctrl_bench
